// ### hdl/ddc_overrange_and_nco_preset_select.sv
// Over-range detection, pulse stretching and NCO preset selection with AHB-Lite registers
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [R01] Gain double bit: 0 dB or 6.02 dB
// [R02] Software enables doubling only with image removed
// [R03] In-phase flag when level reaches threshold
// [R04] Quadrature flag when level reaches threshold
// [R05] Threshold equals value over 256 full scale
// [R06] Pin enable clear holds pins low
// [R07] Stream flags ignore the pin enable
// [R08] Pin pulse lasts eight times two^field
// [R09] Four presets per channel, one active
// [R10] Mode 0 takes preset from register fields
// [R11] Mode 1: each channel its own pins
// [R12] Mode 2: both use channel A pins
// [R13] Single channel follows channel A method
// [R14] Select fields at 1:0 and 3:2
// [R15] Pin 0 in-phase, pin 1 quadrature
// [R16] Preset pins synchronised before use

module sync_fifo
#(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [CNT_W-1:0] count;
    logic not_full;
    logic not_empty;
  } fifo_state_t;

  fifo_state_t state_ff;
  fifo_state_t nxt_state;
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  assign wr_ready = state_ff.not_full;
  assign rd_valid = state_ff.not_empty;
  assign rd_data = state_ff.mem[state_ff.rptr];
  assign push = wr_valid & state_ff.not_full;
  assign pop = rd_ready & state_ff.not_empty;

  always_comb
  begin
    nxt_state = state_ff;
    if (push)
    begin
      nxt_state.mem[state_ff.wptr] = wr_data;
      nxt_state.wptr = ptr_inc(state_ff.wptr);
    end
    if (pop)
    begin
      nxt_state.rptr = ptr_inc(state_ff.rptr);
    end
    if (push && !pop)
    begin
      nxt_state.count = CNT_W'(state_ff.count + 1'b1);
    end
    else if (pop && !push)
    begin
      nxt_state.count = CNT_W'(state_ff.count - 1'b1);
    end
    nxt_state.not_full = (nxt_state.count != CNT_W'(DEPTH));
    nxt_state.not_empty = (nxt_state.count != '0);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= '0;
      state_ff.not_full <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end
endmodule // sync_fifo

module ddc_overrange_and_nco_preset_select
  import ddc_ovr_pkg::*;
#(
  parameter int SAMPLE_W = SAMPLE_W_DEF,
  parameter int FREQ_W = FREQ_W_DEF,
  parameter int PHASE_W = PHASE_W_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [SAMPLE_W-1:0] in_a_i,
  input wire logic [SAMPLE_W-1:0] in_a_q,
  input wire logic [SAMPLE_W-1:0] in_b_i,
  input wire logic [SAMPLE_W-1:0] in_b_q,
  output logic out_valid,
  input wire logic out_ready,
  output logic [SAMPLE_W-1:0] out_a_i,
  output logic [SAMPLE_W-1:0] out_a_q,
  output logic [SAMPLE_W-1:0] out_b_i,
  output logic [SAMPLE_W-1:0] out_b_q,
  output logic out_flag_a_i,
  output logic out_flag_a_q,
  output logic out_flag_b_i,
  output logic out_flag_b_q,
  input wire logic [1:0] preset_pins_chan_a,
  input wire logic [1:0] preset_pins_chan_b,
  output logic ovr_pin_a_i,
  output logic ovr_pin_a_q,
  output logic ovr_pin_b_i,
  output logic ovr_pin_b_q,
  output logic [1:0] active_preset_a,
  output logic [1:0] active_preset_b,
  output logic [FREQ_W-1:0] nco_freq_word_a,
  output logic [PHASE_W-1:0] nco_phase_word_a,
  output logic [FREQ_W-1:0] nco_freq_word_b,
  output logic [PHASE_W-1:0] nco_phase_word_b
);
  localparam int WORD_W = 4 * SAMPLE_W;

  typedef struct packed {
    logic gain_double;
    logic [LEVEL_W-1:0] level_i;
    logic [LEVEL_W-1:0] level_q;
    logic pin_enable;
    logic [2:0] stretch;
    logic [1:0] mode;
    logic [1:0] sel_a;
    logic [1:0] sel_b;
    logic single;
    logic [1:0][3:0][FREQ_W-1:0] freq;
    logic [1:0][3:0][PHASE_W-1:0] phase;
    logic ready;
    logic wr_pend;
    logic [9:0] wr_idx;
    logic [31:0] rdata;
    logic [1:0] pa_meta;
    logic [1:0] pa_sync;
    logic [1:0] pb_meta;
    logic [1:0] pb_sync;
    logic out_valid;
    logic [3:0][SAMPLE_W-1:0] smp;
    logic [3:0] flag;
    logic [3:0][STRETCH_CNT_W-1:0] cnt;
    logic [3:0] pin;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [FREQ_W-1:0] freq_a;
    logic [PHASE_W-1:0] phase_a;
    logic [FREQ_W-1:0] freq_b;
    logic [PHASE_W-1:0] phase_b;
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  logic fifo_valid;
  logic fifo_ready;
  logic [WORD_W-1:0] fifo_data;

  // Doubling with saturation so that a clipped sample keeps its sign
  function automatic logic [SAMPLE_W-1:0] sat_double(input logic [SAMPLE_W-1:0] x);
    if (x[SAMPLE_W-1] != x[SAMPLE_W-2])
    begin
      sat_double = x[SAMPLE_W-1] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
    else
    begin
      sat_double = {x[SAMPLE_W-2:0], 1'b0};
    end
  endfunction

  // Magnitude fits unsigned in SAMPLE_W bits, including the most negative code
  function automatic logic [SAMPLE_W-1:0] abs_level(input logic [SAMPLE_W-1:0] x);
    abs_level = x[SAMPLE_W-1] ? SAMPLE_W'(~x + 1'b1) : x;
  endfunction

  // Threshold of lvl/256 of the full scale 2^(SAMPLE_W-1)
  function automatic logic [SAMPLE_W-1:0] level_scale(input logic [LEVEL_W-1:0] lvl);
    level_scale = {1'b0, lvl, {(SAMPLE_W-LEVEL_W-1){1'b0}}};
  endfunction

  function automatic logic [STRETCH_CNT_W-1:0] stretch_len(input logic [2:0] f);
    stretch_len = STRETCH_CNT_W'(STRETCH_BASE) << f;
  endfunction

  function automatic logic is_preset(input logic [9:0] idx);
    is_preset = (idx[9:4] == IDX_PRESET_BASE[9:4]);
  endfunction

  function automatic logic [31:0] reg_read(input state_t st, input logic [9:0] idx);
    reg_read = '0;
    if (is_preset(idx))
    begin
      if (idx[0])
      begin
        reg_read = 32'(st.phase[idx[3]][idx[2:1]]);
      end
      else
      begin
        reg_read = 32'(st.freq[idx[3]][idx[2:1]]);
      end
    end
    else
    begin
      case (idx)
        IDX_DDC_GAIN: reg_read[BIT_GAIN_DOUBLE] = st.gain_double;
        IDX_LEVEL_I: reg_read[LEVEL_W-1:0] = st.level_i;
        IDX_LEVEL_Q: reg_read[LEVEL_W-1:0] = st.level_q;
        IDX_OVERRANGE_OUTPUT_CONFIG:
        begin
          reg_read[BIT_PIN_ENABLE] = st.pin_enable;
          reg_read[LSB_STRETCH +: 3] = st.stretch;
        end
        IDX_MODE: reg_read[1:0] = st.mode;
        IDX_SEL:
        begin
          reg_read[LSB_SEL_A +: 2] = st.sel_a;
          reg_read[LSB_SEL_B +: 2] = st.sel_b;
        end
        IDX_CHAN_MODE: reg_read[BIT_SINGLE] = st.single;
        default: reg_read = '0;
      endcase
    end
  endfunction

  sync_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data({in_b_q, in_b_i, in_a_q, in_a_i}),
    .rd_valid(fifo_valid),
    .rd_ready(fifo_ready),
    .rd_data(fifo_data)
  );

  // Output stage stalls the FIFO while the consumer holds off
  assign fifo_ready = !state_ff.out_valid | out_ready;

  always_comb
  begin
    logic [1:0] idx_a;
    logic [1:0] idx_b;
    logic [SAMPLE_W-1:0] sample;
    logic take;
    idx_a = '0;
    idx_b = '0;
    sample = '0;
    take = fifo_valid & fifo_ready;
    nxt_state = state_ff;

    // Data phase of a write lands here
    if (state_ff.wr_pend)
    begin
      if (is_preset(state_ff.wr_idx))
      begin
        if (state_ff.wr_idx[0])
        begin
          nxt_state.phase[state_ff.wr_idx[3]][state_ff.wr_idx[2:1]] = hwdata[PHASE_W-1:0]; // [R09]
        end
        else
        begin
          nxt_state.freq[state_ff.wr_idx[3]][state_ff.wr_idx[2:1]] = hwdata[FREQ_W-1:0]; // [R09]
        end
      end
      else
      begin
        case (state_ff.wr_idx)
          IDX_DDC_GAIN: nxt_state.gain_double = hwdata[BIT_GAIN_DOUBLE];
          IDX_LEVEL_I: nxt_state.level_i = hwdata[LEVEL_W-1:0];
          IDX_LEVEL_Q: nxt_state.level_q = hwdata[LEVEL_W-1:0];
          IDX_OVERRANGE_OUTPUT_CONFIG:
          begin
            nxt_state.pin_enable = hwdata[BIT_PIN_ENABLE];
            nxt_state.stretch = hwdata[LSB_STRETCH +: 3];
          end
          IDX_MODE: nxt_state.mode = hwdata[1:0];
          IDX_SEL:
          begin
            nxt_state.sel_a = hwdata[LSB_SEL_A +: 2]; // [R14]
            nxt_state.sel_b = hwdata[LSB_SEL_B +: 2]; // [R14]
          end
          IDX_CHAN_MODE: nxt_state.single = hwdata[BIT_SINGLE];
          default: nxt_state.wr_pend = 1'b0;
        endcase
      end
    end

    // Address phase; reads see a write completing in the same cycle
    nxt_state.wr_pend = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      nxt_state.wr_pend = hwrite && (haddr[1:0] == 2'h0);
      nxt_state.wr_idx = haddr[11:2];
      nxt_state.rdata = '0;
      if (!hwrite && (haddr[1:0] == 2'h0))
      begin
        nxt_state.rdata = reg_read(nxt_state, haddr[11:2]);
      end
    end

    // Two-stage synchronisers for the preset pins
    nxt_state.pa_meta = preset_pins_chan_a; // [R16]
    nxt_state.pa_sync = state_ff.pa_meta; // [R16]
    nxt_state.pb_meta = preset_pins_chan_b; // [R16]
    nxt_state.pb_sync = state_ff.pb_meta; // [R16]

    // Preset index per channel; reserved mode falls back to the register fields
    case (state_ff.mode)
      MODE_PINS_SPLIT:
      begin
        idx_a = state_ff.pa_sync; // [R11]
        idx_b = state_ff.pb_sync; // [R11]
      end
      MODE_PINS_SHARED:
      begin
        idx_a = state_ff.pa_sync; // [R12]
        idx_b = state_ff.pa_sync; // [R12]
      end
      default:
      begin
        idx_a = state_ff.sel_a; // [R10]
        idx_b = state_ff.sel_b; // [R10]
      end
    endcase
    if (state_ff.single)
    begin
      idx_b = idx_a; // [R13]
    end
    nxt_state.act_a = idx_a;
    nxt_state.act_b = idx_b;
    nxt_state.freq_a = state_ff.freq[0][idx_a]; // [R09]
    nxt_state.phase_a = state_ff.phase[0][idx_a]; // [R09]
    nxt_state.freq_b = state_ff.freq[1][idx_b]; // [R09]
    nxt_state.phase_b = state_ff.phase[1][idx_b]; // [R09]

    // Output stage: gain, then level detection on the delivered sample
    if (take)
    begin
      nxt_state.out_valid = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
        sample = fifo_data[k*SAMPLE_W +: SAMPLE_W];
        if (state_ff.gain_double)
        begin
          sample = sat_double(sample); // [R01]
        end
        nxt_state.smp[k] = sample;
        if (k[0])
        begin
          nxt_state.flag[k] = abs_level(sample) >= level_scale(state_ff.level_q); // [R04] [R05] [R07]
        end
        else
        begin
          nxt_state.flag[k] = abs_level(sample) >= level_scale(state_ff.level_i); // [R03] [R05] [R07]
        end
      end
    end
    else if (out_ready)
    begin
      nxt_state.out_valid = 1'b0;
    end

    // Pin stretching: pin k follows flag k of each delivered sample
    for (int k = 0; k < 4; k++)
    begin
      if (take && nxt_state.flag[k])
      begin
        nxt_state.cnt[k] = STRETCH_CNT_W'(stretch_len(state_ff.stretch) - 1'b1); // [R08] [R15]
        nxt_state.pin[k] = state_ff.pin_enable; // [R06] [R15]
      end
      else
      begin
        if (state_ff.cnt[k] != '0)
        begin
          nxt_state.cnt[k] = STRETCH_CNT_W'(state_ff.cnt[k] - 1'b1); // [R08]
        end
        nxt_state.pin[k] = state_ff.pin_enable && (state_ff.cnt[k] != '0); // [R06] [R08]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= '0;
      state_ff.gain_double <= RST_GAIN_DOUBLE;
      state_ff.level_i <= RST_LEVEL_I;
      state_ff.level_q <= RST_LEVEL_Q;
      state_ff.pin_enable <= RST_PIN_ENABLE;
      state_ff.stretch <= RST_STRETCH;
      state_ff.mode <= RST_MODE;
      state_ff.sel_a <= RST_SEL;
      state_ff.sel_b <= RST_SEL;
      state_ff.single <= RST_SINGLE;
      state_ff.ready <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign hreadyout = state_ff.ready;
  assign hresp = 1'b0;
  assign hrdata = state_ff.rdata;
  assign out_valid = state_ff.out_valid;
  assign out_a_i = state_ff.smp[0];
  assign out_a_q = state_ff.smp[1];
  assign out_b_i = state_ff.smp[2];
  assign out_b_q = state_ff.smp[3];
  assign out_flag_a_i = state_ff.flag[0];
  assign out_flag_a_q = state_ff.flag[1];
  assign out_flag_b_i = state_ff.flag[2];
  assign out_flag_b_q = state_ff.flag[3];
  assign ovr_pin_a_i = state_ff.pin[0];
  assign ovr_pin_a_q = state_ff.pin[1];
  assign ovr_pin_b_i = state_ff.pin[2];
  assign ovr_pin_b_q = state_ff.pin[3];
  assign active_preset_a = state_ff.act_a;
  assign active_preset_b = state_ff.act_b;
  assign nco_freq_word_a = state_ff.freq_a;
  assign nco_phase_word_a = state_ff.phase_a;
  assign nco_freq_word_b = state_ff.freq_b;
  assign nco_phase_word_b = state_ff.phase_b;
endmodule // ddc_overrange_and_nco_preset_select
`default_nettype wire

// ### include/ddc_ovr_pkg.sv
// Constants shared by the over-range and NCO preset selection block
package ddc_ovr_pkg;
  // Default widths and depths
  localparam int SAMPLE_W_DEF = 16;
  localparam int FREQ_W_DEF = 32;
  localparam int PHASE_W_DEF = 16;
  localparam int FIFO_DEPTH_DEF = 16;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_DDC_GAIN = 10'h210;
  localparam logic [9:0] IDX_LEVEL_I = 10'h211;
  localparam logic [9:0] IDX_LEVEL_Q = 10'h212;
  localparam logic [9:0] IDX_OVERRANGE_OUTPUT_CONFIG = 10'h213;
  localparam logic [9:0] IDX_MODE = 10'h214;
  localparam logic [9:0] IDX_SEL = 10'h215;
  localparam logic [9:0] IDX_CHAN_MODE = 10'h21f;
  // Preset words: base + chan*8 + preset*2 + (0 freq, 1 phase)
  localparam logic [9:0] IDX_PRESET_BASE = 10'h220;
  // Field positions
  localparam int BIT_GAIN_DOUBLE = 0;
  localparam int BIT_PIN_ENABLE = 3;
  localparam int LSB_STRETCH = 0;
  localparam int LSB_SEL_A = 0;
  localparam int LSB_SEL_B = 2;
  localparam int BIT_SINGLE = 0;
  // Reset values
  localparam logic RST_GAIN_DOUBLE = 1'b0;
  localparam logic [7:0] RST_LEVEL_I = 8'hf2;
  localparam logic [7:0] RST_LEVEL_Q = 8'hab;
  localparam logic RST_PIN_ENABLE = 1'b0;
  localparam logic [2:0] RST_STRETCH = 3'h7;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic RST_SINGLE = 1'b0;
  // Preset selection modes
  localparam logic [1:0] MODE_REGISTER = 2'h0;
  localparam logic [1:0] MODE_PINS_SPLIT = 2'h1;
  localparam logic [1:0] MODE_PINS_SHARED = 2'h2;
  // Pulse stretch: minimum length is STRETCH_BASE << field
  localparam int STRETCH_BASE = 8;
  localparam int STRETCH_CNT_W = 11;
  // Level full scale is 256 steps
  localparam int LEVEL_W = 8;
endpackage

// ### verification/ddc_ovr_checker.sv
// Assertions on the over-range pins, stream flags and preset select ports
`timescale 1ns/10ps
`default_nettype none
module ddc_ovr_checker
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_flag_a_i,
  input wire logic out_flag_a_q,
  input wire logic out_flag_b_i,
  input wire logic out_flag_b_q,
  input wire logic [1:0] preset_pins_chan_a,
  input wire logic [1:0] active_preset_a,
  input wire logic ovr_pin_a_i,
  input wire logic ovr_pin_a_q,
  input wire logic ovr_pin_b_i,
  input wire logic ovr_pin_b_q
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_pin_ai_cause: assert property ($rose(ovr_pin_a_i) |-> out_valid && out_flag_a_i)
    else $error("pin a_i rose without flag");
  a_pin_aq_cause: assert property ($rose(ovr_pin_a_q) |-> out_valid && out_flag_a_q)
    else $error("pin a_q rose without flag");
  a_pin_bi_cause: assert property ($rose(ovr_pin_b_i) |-> out_valid && out_flag_b_i)
    else $error("pin b_i rose without flag");
  a_pin_bq_cause: assert property ($rose(ovr_pin_b_q) |-> out_valid && out_flag_b_q)
    else $error("pin b_q rose without flag");
  a_pin_ai_width: assert property ($rose(ovr_pin_a_i) |-> ovr_pin_a_i [*8])
    else $error("pin a_i pulse too short");
  a_pin_bq_width: assert property ($rose(ovr_pin_b_q) |-> ovr_pin_b_q [*8])
    else $error("pin b_q pulse too short");
  a_flag_i_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable({out_flag_a_i, out_flag_b_i}))
    else $error("in-phase flag moved while stalled");
  a_flag_q_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable({out_flag_a_q, out_flag_b_q}))
    else $error("quadrature flag moved while stalled");
  a_preset_sync: assert property ($changed(preset_pins_chan_a) |=> $stable(active_preset_a) [*2])
    else $error("preset index followed pins too soon");
  cover property ($rose(ovr_pin_a_i));
  cover property (out_valid && !out_ready);
  cover property (active_preset_a == 2'h1);
endmodule // ddc_ovr_checker
`default_nettype wire

// ### verification/host_pin_model.sv
// Host-side model: drives the preset select pins and times over-range pulses
`timescale 1ns/10ps
`default_nettype none
module host_pin_model
(
  input wire logic hclk,
  input wire logic [1:0] want_a,
  input wire logic [1:0] want_b,
  input wire logic ovr_pin_a_i,
  input wire logic ovr_pin_b_q,
  output logic [1:0] preset_pins_chan_a,
  output logic [1:0] preset_pins_chan_b,
  output logic [15:0] len_a_i,
  output logic [15:0] len_b_q
);
  logic [15:0] run_a_ff = 16'h0;
  logic [15:0] run_b_ff = 16'h0;
  initial
  begin
    preset_pins_chan_a = 2'h0;
    preset_pins_chan_b = 2'h0;
    len_a_i = 16'h0;
    len_b_q = 16'h0;
  end
  // Pins move just after an edge; pulse length is stored when a pin falls
  always @(posedge hclk)
  begin
    preset_pins_chan_a <= want_a;
    preset_pins_chan_b <= want_b;
    run_a_ff <= ovr_pin_a_i ? run_a_ff + 16'h1 : 16'h0;
    run_b_ff <= ovr_pin_b_q ? run_b_ff + 16'h1 : 16'h0;
    if (!ovr_pin_a_i && run_a_ff != 16'h0)
      len_a_i <= run_a_ff;
    if (!ovr_pin_b_q && run_b_ff != 16'h0)
      len_b_q <= run_b_ff;
  end
endmodule // host_pin_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the over-range and NCO preset selection block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ddc_ovr_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, in_valid, in_ready, out_valid, out_ready;
  logic [31:0] haddr, hwdata, hrdata, nco_freq_word_a, nco_freq_word_b;
  logic [1:0] htrans, want_a, want_b, preset_pins_chan_a, preset_pins_chan_b;
  logic [1:0] active_preset_a, active_preset_b;
  logic [15:0] in_a_i, in_a_q, in_b_i, in_b_q, out_a_i, out_a_q, out_b_i, out_b_q;
  logic [15:0] nco_phase_word_a, nco_phase_word_b, len_a_i, len_b_q;
  logic out_flag_a_i, out_flag_a_q, out_flag_b_i, out_flag_b_q;
  logic ovr_pin_a_i, ovr_pin_a_q, ovr_pin_b_i, ovr_pin_b_q;
  int failures = 0;
  int checks_done = 0;

  always #10 hclk = ~hclk;

  ddc_overrange_and_nco_preset_select uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .in_valid,
    .in_ready, .in_a_i, .in_a_q, .in_b_i, .in_b_q, .out_valid, .out_ready, .out_a_i, .out_a_q,
    .out_b_i, .out_b_q, .out_flag_a_i, .out_flag_a_q, .out_flag_b_i, .out_flag_b_q,
    .preset_pins_chan_a, .preset_pins_chan_b, .ovr_pin_a_i, .ovr_pin_a_q, .ovr_pin_b_i,
    .ovr_pin_b_q, .active_preset_a, .active_preset_b, .nco_freq_word_a, .nco_phase_word_a,
    .nco_freq_word_b, .nco_phase_word_b);

  host_pin_model host (.hclk, .want_a, .want_b, .ovr_pin_a_i, .ovr_pin_b_q,
    .preset_pins_chan_a, .preset_pins_chan_b, .len_a_i, .len_b_q);

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [31:0] fw(input int c, input int p);
    return 32'((c + 1) * 32'h1000_0000 + p);
  endfunction

  function automatic logic [15:0] pw(input int c, input int p);
    return 16'((c + 1) * 256 + p);
  endfunction

  // One single AHB-Lite transfer; byte address is four times the index
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    if (w)
      hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, idx, d, dummy);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, v);
    check("register", {31'h0, hresp, v}, {32'h0, exp});
  endtask

  task automatic xfer(input logic [63:0] s, input logic [63:0] e, input logic [3:0] f);
    in_valid <= 1'b1;
    {in_a_i, in_a_q, in_b_i, in_b_q} <= s;
    do @(posedge hclk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    out_ready <= 1'b1;
    do @(posedge hclk); while (out_valid !== 1'b1);
    out_ready <= 1'b0;
    check("samples", {out_a_i, out_a_q, out_b_i, out_b_q}, e);
    check("flags", {60'h0, out_flag_a_i, out_flag_a_q, out_flag_b_i, out_flag_b_q}, {60'h0, f});
  endtask

  // Pin to output takes two synchroniser edges and one register edge that also applies the select
  task automatic preset_chk(input int a, input int b);
    repeat (5) @(posedge hclk);
    check("preset a", {14'h0, active_preset_a, nco_freq_word_a, nco_phase_word_a},
      {14'h0, 2'(a), fw(0, a), pw(0, a)});
    check("preset b", {14'h0, active_preset_b, nco_freq_word_b, nco_phase_word_b},
      {14'h0, 2'(b), fw(1, b), pw(1, b)});
  endtask

  task automatic test_regs;
    rd_chk(IDX_DDC_GAIN, 32'h0);
    rd_chk(IDX_LEVEL_I, 32'hf2);
    rd_chk(IDX_LEVEL_Q, 32'hab);
    rd_chk(IDX_OVERRANGE_OUTPUT_CONFIG, 32'h7);
    rd_chk(IDX_MODE, 32'h0);
    rd_chk(IDX_SEL, 32'h0);
    wr(IDX_LEVEL_Q, 32'h1ff);
    rd_chk(IDX_LEVEL_Q, 32'hff);
    wr(IDX_LEVEL_Q, 32'hab);
    wr(10'h3ff, 32'hffff_ffff);
    rd_chk(10'h3ff, 32'h0);
  endtask

  task automatic test_pins;
    wr(IDX_OVERRANGE_OUTPUT_CONFIG, 32'h0);
    xfer(64'h7fff_0000_0000_6000, 64'h7fff_0000_0000_6000, 4'b1001);
    repeat (20) @(posedge hclk);
    check("pulse while off", {32'h0, len_a_i, len_b_q}, 64'h0);
    wr(IDX_OVERRANGE_OUTPUT_CONFIG, 32'h9);
    xfer(64'h7fff_0000_0000_6000, 64'h7fff_0000_0000_6000, 4'b1001);
    repeat (24) @(posedge hclk);
    check("pulse a_i", {48'h0, len_a_i}, 64'(STRETCH_BASE << 1));
    check("pulse b_q", {48'h0, len_b_q}, 64'(STRETCH_BASE << 1));
  endtask

  task automatic test_flags;
    wr(IDX_LEVEL_I, 32'h80);
    xfer(64'h4000_557f_c000_5580, 64'h4000_557f_c000_5580, 4'b1011);
    xfer(64'h3fff_aa80_0000_8001, 64'h3fff_aa80_0000_8001, 4'b0101);
    wr(IDX_DDC_GAIN, 32'h1);
    xfer(64'h2000_7000_e000_1000, 64'h4000_7fff_c000_2000, 4'b1110);
    wr(IDX_DDC_GAIN, 32'h0);
  endtask

  // Consumer stalls while the buffer fills, then drains it in order
  task automatic test_fifo;
    int n;
    n = 0;
    in_valid <= 1'b1;
    {in_a_q, in_b_i, in_b_q} <= 48'h0;
    for (int i = 0; i < 24; i++)
    begin
      in_a_i <= 16'(n);
      @(posedge hclk);
      if (in_ready === 1'b1)
        n++;
    end
    in_valid <= 1'b0;
    check("words held", 64'(n), 64'(FIFO_DEPTH_DEF + 1));
    out_ready <= 1'b1;
    for (int k = 0; k <= FIFO_DEPTH_DEF; k++)
    begin
      do @(posedge hclk); while (out_valid !== 1'b1);
      check("drain order", {48'h0, out_a_i}, 64'(k));
    end
    out_ready <= 1'b0;
    repeat (3) @(posedge hclk);
    check("drained", {63'h0, out_valid}, 64'h0);
  endtask

  task automatic test_presets;
    for (int c = 0; c < 2; c++)
      for (int p = 0; p < 4; p++)
      begin
        wr(IDX_PRESET_BASE + 10'(c * 8 + p * 2), fw(c, p));
        wr(IDX_PRESET_BASE + 10'(c * 8 + p * 2 + 1), {16'h0, pw(c, p)});
      end
    wr(IDX_SEL, 32'he);
    preset_chk(2, 3);
    want_a <= 2'h1;
    want_b <= 2'h2;
    // Let the pins settle first, so a mode change is not mistaken for a pin change
    repeat (4) @(posedge hclk);
    wr(IDX_MODE, 32'h1);
    preset_chk(1, 2);
    want_a <= 2'h3;
    want_b <= 2'h0;
    repeat (3) @(posedge hclk);
    check("sync delay", {62'h0, active_preset_a}, 64'h1);
    preset_chk(3, 0);
    wr(IDX_MODE, 32'h2);
    preset_chk(3, 3);
    wr(IDX_MODE, 32'h3);
    preset_chk(2, 3);
    wr(IDX_MODE, 32'h0);
    wr(IDX_CHAN_MODE, 32'h1);
    preset_chk(2, 2);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    in_valid = 1'b0;
    out_ready = 1'b0;
    {in_a_i, in_a_q, in_b_i, in_b_q} = 64'h0;
    want_a = 2'h0;
    want_b = 2'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    test_regs;
    test_pins;
    test_flags;
    test_fifo;
    test_presets;
    wrap_up;
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    failures++;
    wrap_up;
  end
endmodule // tb_top

bind ddc_overrange_and_nco_preset_select ddc_ovr_checker chk (.hclk, .hresetn, .out_valid,
  .out_ready, .out_flag_a_i, .out_flag_a_q, .out_flag_b_i, .out_flag_b_q, .preset_pins_chan_a,
  .active_preset_a, .ovr_pin_a_i, .ovr_pin_a_q, .ovr_pin_b_i, .ovr_pin_b_q);
`default_nettype wire
